/* File: core/fdo_cfg_top.sv */
/*
 * apb register bank for floppy output driver style, output tri-state and
 * density select, with the pin drivers and parallel port copy of the outputs.
 * assumes controller outputs and density come from logic on pclk.
 */
`timescale 1ns/100ps
// Functional notes
// - output type bit one makes floppy outputs push-pull instead of open drain
// - output control bit seven zero, the default, keeps floppy outputs driven
// - output control bit seven one tri-states every floppy output
// - bits six and seven never affect the parallel port floppy pins
// - density codes 00 and 01 pass the normal density signal unchanged
// - density code 10 forces density one, code 11 forces zero
module fdo_cfg_top #(
    parameter int N_OUT = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fdo_pkg::FDO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller side
    input wire logic [N_OUT-1:0] fdc_out,
    input wire logic dens_in,
    // floppy pins, density on the top bit
    output logic [N_OUT:0] fdd_pin_o,
    output logic [N_OUT:0] fdd_pin_oe,
    // parallel port copy of the floppy outputs
    output logic [N_OUT:0] pp_fdd_o
);
    import fdo_pkg::*;

    initial
    begin
        if (N_OUT < 1)
            $error("fdo_cfg_top: at least one floppy output needed");
    end

    typedef struct packed {
        logic [7:0] out_ctrl;
        logic [7:0] option;
        logic [N_OUT:0] drv;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } fdo_st_t;

    fdo_st_t st_ff;
    fdo_st_t nxt_st;
    logic setup;
    logic access;

    // density selected from the option field
    function automatic logic fdo_dens_pick(input logic [1:0] sel, input logic din);
        logic v;
        v = din;
        unique case (sel)
            FDO_DENS_NORMAL: v = din;
            FDO_DENS_USER: v = din;
            FDO_DENS_FORCE1: v = 1'b1;
            FDO_DENS_FORCE0: v = 1'b0;
        endcase
        return v;
    endfunction : fdo_dens_pick

    // address decode, used on both read and write
    function automatic logic fdo_mapped(input logic [FDO_ADDR_W-1:0] a);
        return (a == FDO_ADDR_OUT_CTRL) || (a == FDO_ADDR_OPTION) || (a == FDO_ADDR_STATUS);
    endfunction : fdo_mapped

    assign setup = psel && !penable;
    assign access = psel && penable;

    // next state: bus answer, register writes and output pipeline
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.drv = {fdo_dens_pick(st_ff.option[FDO_DENS_HI:FDO_DENS_LO], dens_in), fdc_out};
        // answer prepared in setup, shown in the access cycle
        nxt_st.ready = setup;
        nxt_st.slverr = setup && !fdo_mapped(paddr);
        nxt_st.rdata = '0;
        if (setup && !pwrite)
        begin
            unique case (1'b1)
                paddr == FDO_ADDR_OUT_CTRL: nxt_st.rdata[7:0] = st_ff.out_ctrl;
                paddr == FDO_ADDR_OPTION: nxt_st.rdata[7:0] = st_ff.option;
                paddr == FDO_ADDR_STATUS:
                begin
                    nxt_st.rdata[FDO_STAT_DENS] = st_ff.drv[N_OUT];
                    nxt_st.rdata[FDO_STAT_TRI] = st_ff.out_ctrl[FDO_BIT_TRISTATE];
                    nxt_st.rdata[FDO_STAT_PP] = st_ff.out_ctrl[FDO_BIT_PUSH_PULL];
                end
                default: nxt_st.rdata = '0;
            endcase
        end
        // writes land at the access edge that sees pready high
        if (access && pwrite && st_ff.ready)
        begin
            if (paddr == FDO_ADDR_OUT_CTRL)
                nxt_st.out_ctrl = pwdata[7:0];
            if (paddr == FDO_ADDR_OPTION)
                nxt_st.option = pwdata[7:0] & ~FDO_OPTION_RSVD_MASK;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.out_ctrl <= FDO_OUT_CTRL_RST;
            st_ff.option <= FDO_OPTION_RST;
        end
        else
            st_ff <= nxt_st;
    end

    // pin drivers follow the output control bits
    fdo_pad_drv #(
        .W(N_OUT + 1)
    ) u_pad (
        .pclk(pclk),
        .presetn(presetn),
        .push_pull(st_ff.out_ctrl[FDO_BIT_PUSH_PULL]),
        .tristate(st_ff.out_ctrl[FDO_BIT_TRISTATE]),
        .data(st_ff.drv),
        .pin_o(fdd_pin_o),
        .pin_oe(fdd_pin_oe)
    );

    // parallel port copy ignores driver style and tri-state
    assign pp_fdd_o = st_ff.drv;
    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.slverr;

    // checks
    logic pp_mode;
    logic od_mode;
    assign pp_mode = st_ff.out_ctrl[FDO_BIT_PUSH_PULL] && !st_ff.out_ctrl[FDO_BIT_TRISTATE];
    assign od_mode = !st_ff.out_ctrl[FDO_BIT_PUSH_PULL] && !st_ff.out_ctrl[FDO_BIT_TRISTATE];

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence

    property p_push_pull;
        @(posedge pclk) disable iff (!presetn)
            pp_mode |=> (fdd_pin_oe == '1) && (fdd_pin_o == $past(st_ff.drv));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

    property p_open_drain;
        @(posedge pclk) disable iff (!presetn)
            od_mode |=> (fdd_pin_o == '0) && (fdd_pin_oe == ~$past(st_ff.drv));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drive wrong");

    property p_tristate;
        @(posedge pclk) disable iff (!presetn)
            st_ff.out_ctrl[FDO_BIT_TRISTATE] |=> (fdd_pin_oe == '0);
    endproperty
    a_tristate: assert property (p_tristate) else $error("outputs not tri-stated");

    property p_pp_copy;
        @(posedge pclk) disable iff (!presetn)
            ##1 pp_fdd_o == {fdo_dens_pick($past(st_ff.option[FDO_DENS_HI:FDO_DENS_LO]),
                $past(dens_in)), $past(fdc_out)};
    endproperty
    a_pp_copy: assert property (p_pp_copy) else $error("parallel port copy wrong");

    property p_dens_pass;
        @(posedge pclk) disable iff (!presetn)
            !st_ff.option[FDO_DENS_HI] |=> pp_fdd_o[N_OUT] == $past(dens_in);
    endproperty
    a_dens_pass: assert property (p_dens_pass) else $error("density not passed");

    property p_dens_force;
        @(posedge pclk) disable iff (!presetn)
            st_ff.option[FDO_DENS_HI] |=> pp_fdd_o[N_OUT] == !$past(st_ff.option[FDO_DENS_LO]);
    endproperty
    a_dens_force: assert property (p_dens_force) else $error("density not forced");

    property p_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
            (st_ff.option & FDO_OPTION_RSVD_MASK) == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved option bits set");

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
            s_setup ##1 (psel && penable) |-> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no ready in access cycle");

    property p_write_lands;
        @(posedge pclk) disable iff (!presetn)
            (s_answer and (pwrite && paddr == FDO_ADDR_OUT_CTRL)) |=>
                st_ff.out_ctrl == $past(pwdata[7:0]);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write not stored");

    property p_option_lands;
        @(posedge pclk) disable iff (!presetn)
            (s_answer and (pwrite && paddr == FDO_ADDR_OPTION)) |=>
                st_ff.option == ($past(pwdata[7:0]) & ~FDO_OPTION_RSVD_MASK);
    endproperty
    a_option_lands: assert property (p_option_lands) else $error("option not stored");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
            s_setup ##1 s_answer |-> (pslverr == !fdo_mapped(paddr));
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("slave error wrong");

    property p_status_read;
        @(posedge pclk) disable iff (!presetn)
            (s_answer and (!pwrite && paddr == FDO_ADDR_STATUS)) |->
                (prdata[FDO_STAT_TRI] == $past(st_ff.out_ctrl[FDO_BIT_TRISTATE]))
                && (prdata[FDO_STAT_PP] == $past(st_ff.out_ctrl[FDO_BIT_PUSH_PULL]));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");
endmodule : fdo_cfg_top

/* File: core/fdo_pkg.sv */
/*
 * shared constants for the floppy output and density configuration block:
 * register indices, field positions, reset values and density codes.
 * assumes an apb slave with 32-bit data and one register per aligned word.
 */
package fdo_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] FDO_IDX_OUT_CTRL = 8'hf0;
    localparam logic [7:0] FDO_IDX_OPTION = 8'hf1;
    localparam logic [7:0] FDO_IDX_STATUS = 8'hf2;
    localparam int FDO_ADDR_W = 12;
    localparam logic [FDO_ADDR_W-1:0] FDO_ADDR_OUT_CTRL = {2'h0, FDO_IDX_OUT_CTRL, 2'h0};
    localparam logic [FDO_ADDR_W-1:0] FDO_ADDR_OPTION = {2'h0, FDO_IDX_OPTION, 2'h0};
    localparam logic [FDO_ADDR_W-1:0] FDO_ADDR_STATUS = {2'h0, FDO_IDX_STATUS, 2'h0};
    // output control fields
    localparam int FDO_BIT_PUSH_PULL = 6;
    localparam int FDO_BIT_TRISTATE = 7;
    // option register fields
    localparam int FDO_DENS_LO = 2;
    localparam int FDO_DENS_HI = 3;
    localparam logic [7:0] FDO_OPTION_RSVD_MASK = 8'h03;
    // status fields
    localparam int FDO_STAT_DENS = 0;
    localparam int FDO_STAT_TRI = 1;
    localparam int FDO_STAT_PP = 2;
    // reset values
    localparam logic [7:0] FDO_OUT_CTRL_RST = 8'h00;
    localparam logic [7:0] FDO_OPTION_RST = 8'h00;
    // density select codes
    localparam logic [1:0] FDO_DENS_NORMAL = 2'h0;
    localparam logic [1:0] FDO_DENS_USER = 2'h1;
    localparam logic [1:0] FDO_DENS_FORCE1 = 2'h2;
    localparam logic [1:0] FDO_DENS_FORCE0 = 2'h3;
endpackage : fdo_pkg

/* File: core/fdo_pad_drv.sv */
/*
 * per-pin output driver for the floppy interface: open drain, push-pull or
 * tri-stated, selected by two configuration levels. assumes inputs are on pclk.
 */
`timescale 1ns/100ps
module fdo_pad_drv #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration and data
    input wire logic push_pull,
    input wire logic tristate,
    input wire logic [W-1:0] data,
    // pin side
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe
);
    initial
    begin
        if (W < 1)
            $error("fdo_pad_drv: width must be at least one");
    end

    typedef struct packed {
        logic [W-1:0] o;
        logic [W-1:0] oe;
    } fdo_pad_st_t;

    fdo_pad_st_t st_ff;
    fdo_pad_st_t nxt_st;
    wire [W-1:0] bit_o;
    wire [W-1:0] bit_oe;

    // per bit driver choice: push-pull drives the level, open drain only pulls low
    generate
        for (genvar i = 0; i < W; i++)
        begin : g_bit
            assign bit_o[i] = push_pull && !tristate && data[i];
            assign bit_oe[i] = !tristate && (push_pull || !data[i]);
        end
    endgenerate

    // next pad state in one place
    always_comb
    begin
        nxt_st.o = bit_o;
        nxt_st.oe = bit_oe;
    end

    // register pad state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pin_o = st_ff.o;
    assign pin_oe = st_ff.oe;
endmodule : fdo_pad_drv

/* File: sim/tb_floppy_output_density_cfg.sv */
/*
 * self-checking bench for the floppy output and density configuration bank:
 * apb register access, pin driver modes, density forcing, parallel copy.
 * assumes fdo_cfg_top answers apb with zero wait states and pins lag 2 edges.
 */
`timescale 1ns/100ps
module tb_floppy_output_density_cfg;
    import fdo_pkg::*;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [FDO_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] fdc_out;
    logic dens_in;
    logic [8:0] fdd_pin_o;
    logic [8:0] fdd_pin_oe;
    logic [8:0] pp_fdd_o;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] oc_v;
    logic [7:0] opt_v;
    logic [26:0] ex;

    fdo_cfg_top #(.N_OUT(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fdc_out(fdc_out), .dens_in(dens_in),
        .fdd_pin_o(fdd_pin_o), .fdd_pin_oe(fdd_pin_oe), .pp_fdd_o(pp_fdd_o)
    );

    // free running clock, 4 ns period
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // expected {parallel copy, pin value, pin enable}
    function automatic logic [26:0] exp_out(input logic [7:0] oc, input logic [7:0] opt,
                                            input logic [7:0] d, input logic dn);
        logic [8:0] v;
        logic [8:0] o;
        logic [8:0] oe;
        v = {dn, d};
        if (opt[3:2] == FDO_DENS_FORCE1)
            v[8] = 1'b1;
        else if (opt[3:2] == FDO_DENS_FORCE0)
            v[8] = 1'b0;
        if (oc[FDO_BIT_TRISTATE])
        begin
            o = '0;
            oe = '0;
        end
        else if (oc[FDO_BIT_PUSH_PULL])
        begin
            o = v;
            oe = '1;
        end
        else
        begin
            o = '0;
            oe = ~v;
        end
        return {v, o, oe};
    endfunction : exp_out

    // print counts and the verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            summarize();
        end
    end

    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fdc_out = '0;
        dens_in = 1'b0;
        void'($urandom(14));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and unmapped access
        apb(FDO_ADDR_OUT_CTRL, 1'b0, 32'h0);
        chk("out_ctrl reset", rd, {24'h0, FDO_OUT_CTRL_RST});
        apb(FDO_ADDR_OPTION, 1'b0, 32'h0);
        chk("option reset", rd, {24'h0, FDO_OPTION_RST});
        apb(12'hffc, 1'b1, 32'hff);
        chk("unmapped write err", {31'h0, er}, 32'h1);
        apb(12'hffc, 1'b0, 32'h0);
        chk("unmapped read", rd, 32'h0);
        $display("test reset_and_map done");
        // every mode and density code first, then random settings
        for (int i = 0; i < 40; i++)
        begin
            if (i < 12)
            begin
                oc_v = (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'h40 : 8'hc0);
                opt_v = {4'h0, 2'(i / 3), 2'h0};
            end
            else
            begin
                oc_v = 8'($urandom());
                opt_v = 8'($urandom()) & ~FDO_OPTION_RSVD_MASK;
            end
            apb(FDO_ADDR_OUT_CTRL, 1'b1, {24'h0, oc_v});
            apb(FDO_ADDR_OPTION, 1'b1, {24'h0, opt_v});
            @(posedge pclk);
            fdc_out <= 8'($urandom());
            dens_in <= 1'($urandom());
            repeat (3) @(posedge pclk);
            ex = exp_out(oc_v, opt_v, fdc_out, dens_in);
            chk("pp copy", {23'h0, pp_fdd_o}, {23'h0, ex[26:18]});
            chk("pin value", {23'h0, fdd_pin_o}, {23'h0, ex[17:9]});
            chk("pin enable", {23'h0, fdd_pin_oe}, {23'h0, ex[8:0]});
            chk("density pin", {31'h0, fdd_pin_oe[8] | fdd_pin_o[8]},
                {31'h0, ex[17] | ex[8]});
            apb(FDO_ADDR_OPTION, 1'b0, 32'h0);
            chk("option readback", rd, {24'h0, opt_v});
            apb(FDO_ADDR_OUT_CTRL, 1'b0, 32'h0);
            chk("out_ctrl readback", rd, {24'h0, oc_v});
            chk("mapped read err", {31'h0, er}, 32'h0);
            apb(FDO_ADDR_STATUS, 1'b0, 32'h0);
            chk("status", rd,
                {29'h0, oc_v[FDO_BIT_PUSH_PULL], oc_v[FDO_BIT_TRISTATE], ex[26]});
        end
        $display("test modes_and_density done");
        summarize();
    end
endmodule : tb_floppy_output_density_cfg
